// ===== hdl/col_filter.sv
// Column input glitch filter: with filtering on, a level must hold for the
// filter time before it is passed; with filtering off, inputs pass after one flop.
`timescale 1ns/1ps
module col_filter
	import keyscan_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control
	input wire logic filt_en,
	// Columns
	input wire logic [7:0] col_in,
	output logic [7:0] col_out
);
	typedef struct packed {
		logic [7:0][4:0] cnt;
		logic [7:0] q;
	} filt_s;

	filt_s st_reg, st_next;

	always_comb begin
		st_next = st_reg;
		for (int i = 0; i < 8; i++) begin
			if (!filt_en || col_in[i] == st_reg.q[i]) begin
				st_next.q[i] = col_in[i];
				st_next.cnt[i] = '0;
			end else if (st_reg.cnt[i] == FILT_CYC - 5'h01) begin
				// Stable for the full filter time: accept the new level
				st_next.q[i] = col_in[i];
				st_next.cnt[i] = '0;
			end else begin
				st_next.cnt[i] = st_reg.cnt[i] + 5'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_reg <= '{cnt: '0, q: 8'hff};
		end else begin
			st_reg <= st_next;
		end
	end

	assign col_out = st_reg.q;
endmodule // col_filter

// ===== hdl/keyscan_pkg.sv
// Shared constants for the keypad scan controller: register map, field layout,
// timing figures and state enumerations.
// Assumes a single 200 MHz system clock.
package keyscan_pkg;

	// ==========================================================================
	// Clock and timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int MS_NS = 1000000;
	localparam int TICK_CYC_DEF = MS_NS / CLK_PERIOD_NS;
	localparam int FILT_NS = 100;
	localparam int FILT_CYC_I = (FILT_NS / CLK_PERIOD_NS < 1) ? 1 : FILT_NS / CLK_PERIOD_NS;
	localparam logic [4:0] FILT_CYC = 5'(FILT_CYC_I);
	localparam logic [4:0] ROW_SETTLE_CYC = 5'(FILT_CYC_I + 4);

	// Debounce waits, in ms
	localparam logic [10:0] DB1_SLOW_MS = 11'h006;
	localparam logic [10:0] DB2_SLOW_MS = 11'h008;
	localparam logic [10:0] DB1_FAST_MS = 11'h003;
	localparam logic [10:0] DB2_FAST_MS = 11'h004;
	// Auto-clear timeouts, in ms
	localparam logic [10:0] AC_SHORT_MS = 11'h005;
	localparam logic [10:0] AC_LONG_MS = 11'h00a;
	// Long-press repeat delays, in ms
	localparam logic [10:0] HOLD_MS_0 = 11'h014;
	localparam logic [10:0] HOLD_MS_1 = 11'h028;
	localparam logic [10:0] HOLD_MS_2 = 11'h3e8;
	localparam logic [10:0] HOLD_MS_3 = 11'h7d0;

	// ==========================================================================
	// Register map and fields
	localparam logic [7:0] SCAN_SETUP_ADDR = 8'h08;
	localparam logic [7:0] KEY_STATUS_ADDR = 8'h10;
	localparam logic [7:0] SCAN_SETUP_RST = 8'h10;
	localparam logic [7:0] SCAN_SETUP_WMASK = 8'h7f;
	localparam int ACI_LSB = 5;
	localparam int DE_BIT = 4;
	localparam int SD_BIT = 3;
	localparam int LE_BIT = 2;
	localparam int LT_LSB = 0;
	localparam logic [1:0] ACI_OFF = 2'h0;
	localparam logic [1:0] ACI_SHORT = 2'h1;
	localparam logic [1:0] ACI_LONG = 2'h2;
	localparam logic [4:0] SLAVE_ADDR_HI = 5'h16;

	// ==========================================================================
	// State machines
	typedef enum logic [3:0] {
		I_IDLE, I_ADDR, I_ADDR_ACK, I_REG, I_REG_ACK, I_WR, I_RD, I_RD_ACK
	} ser_state_e;

	typedef enum logic [2:0] {
		K_IDLE, K_ROW, K_WAIT, K_REPORT, K_HOLD
	} scan_state_e;

endpackage

// ===== hdl/keyscan_top.sv
// Keypad scan controller: two-wire serial register slave, 8x8 matrix scan with
// triple-scan debounce, event queue, interrupt, auto-clear and long-press repeat.
// Assumes serial and column inputs already synchronous to SYS_CLK, pulled-up
// columns, and a supply monitor giving SUPPLY_OK.
//
// Functional notes
// - Registers and serial port held at defaults while supply is below threshold.
// - Bus abort voids serial transfer, returns to idle, interrupt untouched.
// - Standby entered automatically when serial and keypad are both idle.
// - In standby all eight rows are driven low.
// - A keypad change triggers three full matrix scans separated by debounce waits.
// - Interrupt asserts once debounced events are stored.
// - Status reads return pending events lowest key code first.
// - Without auto-clear, interrupt stays low until every event is read.
// - Debounce waits are 6 and 8 ms, or 3 and 4 ms with speed bit set.
// - Agreeing scans that show a change latch and interrupt; otherwise nothing latched, back to standby.
// - Long-press detection follows its enable bit.
// - With long-press on, held keys are rescanned and re-reported after deassertion.
// - Delay from deassertion to rescan comes from the two-bit delay field.
// - Keypad changes are ignored while the interrupt is asserted.
// - After all events are read the device returns to standby, unless long-press is on and a key is still held.
// - Auto-clear field 01/10 deasserts interrupt after 5/10 ms; 00 disables.
// - Auto-clear leaves stored events readable until a new key event.
// - Status register is readable at any time.
// - A new event after auto-clear overwrites old events and reasserts interrupt.
// - Filter bit off passes any change; on rejects pulses under 100 ns.
// - Event byte is more flag, press state, then column*8+row key code.
// - Reading the last event leaves status zero and clears the interrupt.
// - Long-press delay codes select 20 ms, 40 ms, 1 s, 2 s.
// - Several keys on one column: only the first pressed key is reported.
`timescale 1ns/1ps
module keyscan_top
	import keyscan_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYC_DEF
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic SUPPLY_OK,
	// Serial register port
	input wire logic BUS_ABORT_B,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic [1:0] ADDR_SEL,
	// Keypad matrix
	input wire logic [7:0] COLUMN_SENSE_INPUTS,
	output logic [7:0] ROW_DRIVE_OUTPUTS,
	// Host signalling
	output logic INT_B,
	output logic STANDBY
);
	typedef struct packed {
		ser_state_e ist;
		logic scl_q;
		logic sda_q;
		logic [3:0] bitc;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic rw;
		logic sda_oe;
		logic [7:0] scan_setup;
		scan_state_e kst;
		logic [2:0] row;
		logic [4:0] settle;
		logic [1:0] scan_n;
		logic [63:0] snap;
		logic [63:0] s0;
		logic [63:0] s1;
		logic [63:0] key_state;
		logic [63:0] pend;
		logic [10:0] ms;
		logic hold;
		logic int_b;
		logic [7:0] rows;
		logic standby;
	} top_s;

	top_s st_reg, st_next;
	logic rst_all_b;
	logic ms_tick;
	logic [7:0] col_f;

	assign rst_all_b = RST_B & SUPPLY_OK;

	// ==========================================================================
	// Timebase and column filter
	tick_div #(.CYCLES(TICK_CYC)) u_tick (
		.clk(SYS_CLK),
		.rst_b(rst_all_b),
		.tick(ms_tick)
	);

	col_filter u_filt (
		.clk(SYS_CLK),
		.rst_b(rst_all_b),
		.filt_en(st_reg.scan_setup[DE_BIT]),
		.col_in(COLUMN_SENSE_INPUTS),
		.col_out(col_f)
	);

	// ==========================================================================
	// Helpers
	function automatic logic [5:0] first_set(input logic [63:0] v);
		logic [5:0] idx;
		idx = '0;
		for (int i = 63; i >= 0; i--) begin
			if (v[i]) begin
				idx = 6'(i);
			end
		end
		return idx;
	endfunction

	// Per column keep an already-held key, else only the lowest new row
	function automatic logic [63:0] one_per_col(input logic [63:0] neu, input logic [63:0] old);
		logic [63:0] r;
		logic [7:0] o;
		logic [7:0] n;
		r = '0;
		for (int c = 0; c < 8; c++) begin
			o = old[c*8 +: 8];
			n = neu[c*8 +: 8];
			if ((o & n) != 8'h00) begin
				r[c*8 +: 8] = o & n;
			end else begin
				r[c*8 +: 8] = n & (8'(~n) + 8'h01);
			end
		end
		return r;
	endfunction

	logic start_c, stop_c, rise_c, fall_c;
	logic [7:0] status_byte, rd_byte, exp_col;
	logic [5:0] low_code;
	logic more_c, pop_c, change_c, agree_c;
	logic [63:0] acc_c, ev_c;
	logic [10:0] wait_ms, hold_ms, ac_ms;

	// ==========================================================================
	// Combinational datapath
	always_comb begin
		low_code = first_set(st_reg.pend);
		more_c = (st_reg.pend & (st_reg.pend - 64'h1)) != 64'h0;
		if (st_reg.pend == 64'h0) begin
			status_byte = 8'h00;
		end else begin
			status_byte = {more_c, st_reg.key_state[low_code], low_code};
		end
		case (st_reg.ptr)
			SCAN_SETUP_ADDR: rd_byte = st_reg.scan_setup & SCAN_SETUP_WMASK;
			KEY_STATUS_ADDR: rd_byte = status_byte;
			default: rd_byte = 8'h00;
		endcase
		for (int c = 0; c < 8; c++) begin
			exp_col[c] = |st_reg.key_state[c*8 +: 8];
		end
		change_c = (~col_f) != exp_col;
		agree_c = (st_reg.snap == st_reg.s0) && (st_reg.snap == st_reg.s1);
		acc_c = one_per_col(st_reg.snap, st_reg.key_state);
		ev_c = (acc_c ^ st_reg.key_state) | (st_reg.hold ? acc_c : 64'h0);
		if (st_reg.scan_n == 2'h1) begin
			wait_ms = st_reg.scan_setup[SD_BIT] ? DB1_FAST_MS : DB1_SLOW_MS;
		end else begin
			wait_ms = st_reg.scan_setup[SD_BIT] ? DB2_FAST_MS : DB2_SLOW_MS;
		end
		case (st_reg.scan_setup[LT_LSB +: 2])
			2'h0: hold_ms = HOLD_MS_0;
			2'h1: hold_ms = HOLD_MS_1;
			2'h2: hold_ms = HOLD_MS_2;
			default: hold_ms = HOLD_MS_3;
		endcase
		case (st_reg.scan_setup[ACI_LSB +: 2])
			ACI_SHORT: ac_ms = AC_SHORT_MS;
			ACI_LONG: ac_ms = AC_LONG_MS;
			default: ac_ms = '0;
		endcase
		start_c = st_reg.scl_q && SCL_IN && st_reg.sda_q && !SDA_IN;
		stop_c = st_reg.scl_q && SCL_IN && !st_reg.sda_q && SDA_IN;
		rise_c = !st_reg.scl_q && SCL_IN;
		fall_c = st_reg.scl_q && !SCL_IN;
	end

	// ==========================================================================
	// Next-state logic
	always_comb begin
		st_next = st_reg;
		pop_c = 1'b0;
		st_next.scl_q = SCL_IN;
		st_next.sda_q = SDA_IN;

		// Serial slave
		case (st_reg.ist)
			I_IDLE: begin
			end
			I_ADDR, I_REG, I_WR: begin
				if (rise_c) begin
					st_next.sh = {st_reg.sh[6:0], SDA_IN};
					st_next.bitc = st_reg.bitc + 4'h1;
				end else if (fall_c && st_reg.bitc == 4'h8) begin
					st_next.bitc = '0;
					if (st_reg.ist == I_ADDR) begin
						if (st_reg.sh[7:1] == {SLAVE_ADDR_HI, ADDR_SEL}) begin
							st_next.sda_oe = 1'b1;
							st_next.rw = st_reg.sh[0];
							st_next.ist = I_ADDR_ACK;
						end else begin
							st_next.ist = I_IDLE;
						end
					end else begin
						if (st_reg.ist == I_REG) begin
							st_next.ptr = st_reg.sh;
						end else if (st_reg.ptr == SCAN_SETUP_ADDR) begin
							st_next.scan_setup = st_reg.sh & SCAN_SETUP_WMASK;
						end
						st_next.sda_oe = 1'b1;
						st_next.ist = I_REG_ACK;
					end
				end
			end
			I_ADDR_ACK: begin
				if (fall_c) begin
					if (st_reg.rw) begin
						st_next.sh = rd_byte;
						st_next.sda_oe = ~rd_byte[7];
						st_next.bitc = '0;
						st_next.ist = I_RD;
					end else begin
						st_next.sda_oe = 1'b0;
						st_next.ist = I_REG;
					end
				end
			end
			I_REG_ACK: begin
				if (fall_c) begin
					st_next.sda_oe = 1'b0;
					st_next.ist = I_WR;
				end
			end
			I_RD: begin
				if (fall_c) begin
					if (st_reg.bitc == 4'h7) begin
						// Whole byte sent: a status byte counts as consumed
						st_next.sda_oe = 1'b0;
						st_next.ist = I_RD_ACK;
						pop_c = (st_reg.ptr == KEY_STATUS_ADDR);
					end else begin
						st_next.sh = {st_reg.sh[6:0], 1'b0};
						st_next.sda_oe = ~st_reg.sh[6];
						st_next.bitc = st_reg.bitc + 4'h1;
					end
				end
			end
			I_RD_ACK: begin
				if (rise_c) begin
					st_next.ist = SDA_IN ? I_IDLE : I_ADDR_ACK;
				end
			end
			default: st_next.ist = I_IDLE;
		endcase
		if (start_c) begin
			st_next.ist = I_ADDR;
			st_next.bitc = '0;
			st_next.sda_oe = 1'b0;
		end else if (stop_c) begin
			st_next.ist = I_IDLE;
			st_next.sda_oe = 1'b0;
		end
		if (!BUS_ABORT_B) begin
			// Interrupt and scan state deliberately untouched
			st_next.ist = I_IDLE;
			st_next.sda_oe = 1'b0;
		end

		// Event queue drain, allowed in any scan state
		if (pop_c && st_reg.pend != 64'h0) begin
			st_next.pend[low_code] = 1'b0;
		end
		if (ms_tick) begin
			st_next.ms = st_reg.ms + 11'h001;
		end

		// Scan engine
		case (st_reg.kst)
			K_IDLE: begin
				st_next.rows = 8'h00;
				st_next.hold = 1'b0;
				if (st_reg.settle != ROW_SETTLE_CYC) begin
					// Filtered columns still show the last scanned row for a while
					st_next.settle = st_reg.settle + 5'h01;
				end else if (change_c) begin
					st_next.kst = K_ROW;
					st_next.row = '0;
					st_next.settle = '0;
					st_next.scan_n = '0;
					st_next.rows = ~8'h01;
				end
			end
			K_ROW: begin
				// Settle covers the filter delay so a sample sees the driven row
				if (st_reg.settle != ROW_SETTLE_CYC) begin
					st_next.settle = st_reg.settle + 5'h01;
				end else begin
					for (int c = 0; c < 8; c++) begin
						st_next.snap[c*8 + int'(st_reg.row)] = ~col_f[c];
					end
					st_next.settle = '0;
					st_next.row = st_reg.row + 3'h1;
					st_next.rows = ~(8'h01 << (st_reg.row + 3'h1));
					if (st_reg.row == 3'h7) begin
						st_next.rows = 8'h00;
						st_next.ms = '0;
						st_next.scan_n = st_reg.scan_n + 2'h1;
						st_next.kst = K_WAIT;
						if (st_reg.scan_n == 2'h0) begin
							st_next.s0 = st_next.snap;
						end else if (st_reg.scan_n == 2'h1) begin
							st_next.s1 = st_next.snap;
						end
					end
				end
			end
			K_WAIT: begin
				if (st_reg.scan_n == 2'h3) begin
					if (agree_c && ev_c != 64'h0) begin
						st_next.key_state = acc_c;
						st_next.pend = ev_c;
						st_next.int_b = 1'b0;
						st_next.ms = '0;
						st_next.kst = K_REPORT;
					end else begin
						st_next.kst = K_IDLE;
					end
				end else if (st_reg.ms >= wait_ms) begin
					st_next.kst = K_ROW;
					st_next.row = '0;
					st_next.settle = '0;
					st_next.rows = ~8'h01;
				end
			end
			K_REPORT: begin
				// Column changes are not looked at here
				st_next.rows = 8'h00;
				if ((pop_c && !more_c) || st_reg.pend == 64'h0 ||
						(ac_ms != '0 && st_reg.ms >= ac_ms)) begin
					st_next.int_b = 1'b1;
					st_next.ms = '0;
					// Auto-clear leaves pend as it is
					if (st_reg.scan_setup[LE_BIT] && st_reg.key_state != 64'h0) begin
						st_next.kst = K_HOLD;
					end else begin
						st_next.kst = K_IDLE;
					end
				end
			end
			K_HOLD: begin
				st_next.rows = 8'h00;
				if (st_reg.ms >= hold_ms) begin
					st_next.kst = K_ROW;
					st_next.hold = 1'b1;
					st_next.row = '0;
					st_next.settle = '0;
					st_next.scan_n = '0;
					st_next.rows = ~8'h01;
				end
			end
			default: st_next.kst = K_IDLE;
		endcase
		st_next.standby = (st_next.kst == K_IDLE) && (st_next.ist == I_IDLE);
	end

	// ==========================================================================
	// State register
	always_ff @(posedge SYS_CLK) begin
		if (!rst_all_b) begin
			st_reg <= '0;
			st_reg.ist <= I_IDLE;
			st_reg.kst <= K_IDLE;
			st_reg.scl_q <= 1'b1;
			st_reg.sda_q <= 1'b1;
			st_reg.scan_setup <= SCAN_SETUP_RST;
			st_reg.int_b <= 1'b1;
			st_reg.standby <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================================
	// Outputs
	// Open-drain line: only ever pulled low, the enable carries the data
	assign SDA_OUT = 1'b0;
	assign SDA_OE = st_reg.sda_oe;
	assign ROW_DRIVE_OUTPUTS = st_reg.rows;
	assign INT_B = st_reg.int_b;
	assign STANDBY = st_reg.standby;
endmodule // keyscan_top

// ===== hdl/tick_div.sv
// Millisecond timebase: one-cycle enable pulse every CYCLES system clocks.
// Assumes synchronous active-low reset.
`timescale 1ns/1ps
module tick_div
	import keyscan_pkg::*;
#(
	parameter int unsigned CYCLES = TICK_CYC_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Timebase pulse
	output logic tick
);
	typedef struct packed {
		logic [$clog2(CYCLES+1)-1:0] cnt;
		logic tick;
	} tick_s;

	tick_s st_reg, st_next;

	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (st_reg.cnt == ($bits(st_reg.cnt))'(CYCLES - 1)) begin
			st_next.cnt = '0;
			st_next.tick = 1'b1;
		end else begin
			st_next.cnt = st_reg.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick = st_reg.tick;
endmodule // tick_div

// ===== verif/keypad_matrix_scan_debounce_tb_top.sv
// Self-checking bench for the keypad scan controller.
// Assumes a 20-cycle millisecond tick and a pulled-up serial data line.
`timescale 1ns/1ps
`define CHK(a, e) begin \
	cmp_count++; \
	if ((a) !== (e)) begin \
		miscompares++; \
		$display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); \
	end \
end
module keypad_matrix_scan_debounce_tb_top import keyscan_pkg::*;;
	localparam int TCK = 20;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic supply_ok = 1'b1;
	logic abort_b = 1'b1;
	logic scl = 1'b1;
	logic sda_m = 1'b1;
	logic [1:0] addr_sel = 2'h0;
	logic [63:0] keys = 64'h0;
	logic sda_out;
	logic sda_oe;
	logic int_b;
	logic standby;
	logic [7:0] rows;
	logic [7:0] cols;
	int cmp_count = 0;
	int miscompares = 0;
	// Open-drain data line with pull-up
	wire logic sda_w = sda_m & ~sda_oe;

	keyscan_top #(.TICK_CYC(TCK)) u_keyscan_top (
		.SYS_CLK(sys_clk),
		.RST_B(rst_b),
		.SUPPLY_OK(supply_ok),
		.BUS_ABORT_B(abort_b),
		.SCL_IN(scl),
		.SDA_IN(sda_w),
		.SDA_OUT(sda_out),
		.SDA_OE(sda_oe),
		.ADDR_SEL(addr_sel),
		.COLUMN_SENSE_INPUTS(cols),
		.ROW_DRIVE_OUTPUTS(rows),
		.INT_B(int_b),
		.STANDBY(standby)
	);
	keypad_model u_keypad_model (.rows(rows), .keys(keys), .cols(cols));

	always #2.5 sys_clk = ~sys_clk;

	// ==========================================================================
	// Expectations
	function automatic logic [7:0] ev(input logic more, input logic press, input int k);
		return {more, press, 6'(k)};
	endfunction
	function automatic int db_ms(input logic sd);
		return int'(sd ? DB1_FAST_MS + DB2_FAST_MS : DB1_SLOW_MS + DB2_SLOW_MS);
	endfunction

	// ==========================================================================
	// Serial master, four system clocks per clock phase
	task automatic results();
		$display("checks %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic ph();
		repeat (4) @(negedge sys_clk);
	endtask
	task automatic start();
		sda_m = 1'b1;
		ph();
		scl = 1'b1;
		ph();
		sda_m = 1'b0;
		ph();
		scl = 1'b0;
	endtask
	task automatic stop();
		sda_m = 1'b0;
		ph();
		scl = 1'b1;
		ph();
		sda_m = 1'b1;
		ph();
	endtask
	task automatic sbit(input logic v, output logic s);
		sda_m = v;
		ph();
		scl = 1'b1;
		ph();
		s = sda_w;
		scl = 1'b0;
	endtask
	task automatic sbyte(input logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) sbit(b[i], s);
		sbit(1'b1, s);
		`CHK(s, 1'b0)
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		start();
		sbyte({SLAVE_ADDR_HI, addr_sel, 1'b0});
		sbyte(a);
		sbyte(d);
		stop();
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		logic s;
		start();
		sbyte({SLAVE_ADDR_HI, addr_sel, 1'b0});
		sbyte(a);
		start();
		sbyte({SLAVE_ADDR_HI, addr_sel, 1'b1});
		for (int i = 7; i >= 0; i--) sbit(1'b1, d[i]);
		sbit(1'b1, s);
		stop();
	endtask
	// Waits for interrupt (sel 0) or standby (sel 1) to reach level v
	task automatic wait_lvl(input logic sel, input logic v, output int n);
		n = 0;
		while ((sel ? standby : int_b) !== v) begin
			@(negedge sys_clk);
			n++;
			if (n > 5000) begin
				miscompares++;
				results();
			end
		end
	endtask
	task automatic check_key(input logic more, input logic press, input int k);
		logic [7:0] d;
		reg_rd(KEY_STATUS_ADDR, d);
		`CHK(d, ev(more, press, k))
	endtask

	// ==========================================================================
	// Tests
	initial begin
		logic [7:0] d;
		logic sd;
		int n;
		int k;
		int j;
		void'($urandom(32'h719e3153));
		addr_sel = 2'($urandom);
		repeat (20) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (2) @(negedge sys_clk);
		`CHK(int_b, 1'b1)
		`CHK(rows, 8'h00)
		`CHK(sda_out, 1'b0)
		reg_rd(SCAN_SETUP_ADDR, d);
		`CHK(d, SCAN_SETUP_RST)
		reg_rd(8'h20, d);
		`CHK(d, 8'h00)
		reg_rd(KEY_STATUS_ADDR, d);
		`CHK(d, 8'h00)
		reg_wr(SCAN_SETUP_ADDR, 8'hff);
		reg_rd(SCAN_SETUP_ADDR, d);
		`CHK(d, SCAN_SETUP_WMASK)
		supply_ok = 1'b0;
		repeat (2) @(negedge sys_clk);
		supply_ok = 1'b1;
		reg_rd(SCAN_SETUP_ADDR, d);
		`CHK(d, SCAN_SETUP_RST)
		// Wrong address bits must be left unanswered
		d = {SLAVE_ADDR_HI, ~addr_sel, 1'b0};
		start();
		for (int i = 7; i >= 0; i--) sbit(d[i], sd);
		sbit(1'b1, sd);
		`CHK(sd, 1'b1)
		stop();
		$display("test reset_regs done");
		for (int i = 0; i < 4; i++) begin
			sd = 1'($urandom);
			k = (i == 0) ? 0 : (i == 1) ? 63 : $urandom_range(62, 1);
			reg_wr(SCAN_SETUP_ADDR, {3'h0, 1'($urandom), sd, 3'h0});
			keys[k] = 1'b1;
			wait_lvl(1'b0, 1'b0, n);
			`CHK(n >= (db_ms(sd) - 2) * TCK + 600 && n <= (db_ms(sd) + 2) * TCK + 700, 1'b1)
			repeat (16 * TCK) @(negedge sys_clk);
			`CHK(int_b, 1'b0)
			check_key(1'b0, 1'b1, k);
			`CHK(int_b, 1'b1)
			reg_rd(KEY_STATUS_ADDR, d);
			`CHK(d, 8'h00)
			`CHK(standby, 1'b1)
			// Held key with long-press off: no rescan may follow
			n = 0;
			repeat (70 * TCK) begin
				@(negedge sys_clk);
				n += (standby !== 1'b1);
			end
			`CHK(n, 0)
			keys[k] = 1'b0;
			wait_lvl(1'b0, 1'b0, n);
			check_key(1'b0, 1'b0, k);
		end
		$display("test single_keys done");
		k = $urandom_range(31);
		j = 32 + $urandom_range(31);
		keys[k] = 1'b1;
		keys[j] = 1'b1;
		wait_lvl(1'b0, 1'b0, n);
		check_key(1'b1, 1'b1, k);
		check_key(1'b0, 1'b1, j);
		keys[k ^ 1] = 1'b1;
		n = 0;
		repeat (2000) begin
			@(negedge sys_clk);
			n += (int_b !== 1'b1);
		end
		`CHK(n, 0)
		keys = 64'h0;
		wait_lvl(1'b0, 1'b0, n);
		check_key(1'b1, 1'b0, k);
		check_key(1'b0, 1'b0, j);
		$display("test multi_keys done");
		for (int a = 1; a < 3; a++) begin
			k = $urandom_range(63);
			reg_wr(SCAN_SETUP_ADDR, {1'b0, 2'(a), 5'h08});
			keys[k] = 1'b1;
			wait_lvl(1'b0, 1'b0, n);
			wait_lvl(1'b0, 1'b1, n);
			j = int'(a == 1 ? AC_SHORT_MS : AC_LONG_MS) * TCK;
			`CHK(n >= j - TCK && n <= j + TCK, 1'b1)
			if (a == 1) begin
				check_key(1'b0, 1'b1, k);
			end
			keys[k] = 1'b0;
			wait_lvl(1'b0, 1'b0, n);
			check_key(1'b0, 1'b0, k);
		end
		$display("test auto_clear done");
		k = $urandom_range(63);
		reg_wr(SCAN_SETUP_ADDR, 8'h0c);
		keys[k] = 1'b1;
		wait_lvl(1'b0, 1'b0, n);
		check_key(1'b0, 1'b1, k);
		wait_lvl(1'b0, 1'b0, n);
		j = int'(HOLD_MS_0) + db_ms(1'b1);
		`CHK(n >= (j - 3) * TCK + 500 && n <= (j + 3) * TCK + 700, 1'b1)
		check_key(1'b0, 1'b1, k);
		keys[k] = 1'b0;
		wait_lvl(1'b0, 1'b0, n);
		check_key(1'b0, 1'b0, k);
		$display("test long_press done");
		for (int f = 0; f < 2; f++) begin
			reg_wr(SCAN_SETUP_ADDR, {3'h0, 1'(f), 4'h8});
			k = $urandom_range(63);
			keys[k] = 1'b1;
			repeat (10) @(negedge sys_clk);
			keys[k] = 1'b0;
			n = 0;
			repeat (40) begin
				@(negedge sys_clk);
				n += (standby !== 1'b1);
			end
			`CHK(n == 0, f == 1)
			wait_lvl(1'b1, 1'b1, n);
			`CHK(int_b, 1'b1)
		end
		$display("test glitch_filter done");
		k = $urandom_range(63);
		keys[k] = 1'b1;
		wait_lvl(1'b0, 1'b0, n);
		start();
		sbyte({SLAVE_ADDR_HI, addr_sel, 1'b0});
		sbyte(KEY_STATUS_ADDR);
		start();
		sbyte({SLAVE_ADDR_HI, addr_sel, 1'b1});
		abort_b = 1'b0;
		repeat (4) @(negedge sys_clk);
		`CHK(sda_oe, 1'b0)
		`CHK(int_b, 1'b0)
		abort_b = 1'b1;
		stop();
		check_key(1'b0, 1'b1, k);
		keys[k] = 1'b0;
		wait_lvl(1'b0, 1'b0, n);
		check_key(1'b0, 1'b0, k);
		$display("test bus_abort done");
		results();
	end
endmodule // keypad_matrix_scan_debounce_tb_top

// ===== verif/keypad_model.sv
// Passive 8x8 switch matrix: a closed key joins its row to its column.
// Assumes pulled-up columns; key index is column*8 + row.
`timescale 1ns/1ps
module keypad_model (
	// Matrix
	input wire logic [7:0] rows,
	input wire logic [63:0] keys,
	output logic [7:0] cols
);
	always_comb begin
		for (int c = 0; c < 8; c++) begin
			cols[c] = ~|(~rows & keys[c*8 +: 8]);
		end
	end
endmodule // keypad_model

// ===== verif/keyscan_asserts.sv
// Checker for the keypad scan controller, bound to its top module.
// Assumes only top-level ports are seen; one scan is 8 rows of 25 cycles.
`timescale 1ns/1ps
module keyscan_asserts
	import keyscan_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYC_DEF
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic SUPPLY_OK,
	// Serial port
	input wire logic BUS_ABORT_B,
	input wire logic SCL_IN,
	input wire logic SDA_OE,
	// Keypad and host
	input wire logic [7:0] ROW_DRIVE_OUTPUTS,
	input wire logic INT_B,
	input wire logic STANDBY
);
	// ==========================================================================
	// Row-scan cycles since the last interrupt; saturates so it never wraps
	logic [11:0] scan_cnt_reg;
	always_ff @(posedge SYS_CLK) begin
		if (!RST_B || !SUPPLY_OK || $fell(INT_B)) begin
			scan_cnt_reg <= 12'h000;
		end else if (ROW_DRIVE_OUTPUTS != 8'h00 && scan_cnt_reg != 12'hfff) begin
			scan_cnt_reg <= scan_cnt_reg + 12'h001;
		end
	end

	// ==========================================================================
	// Properties
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_B || !SUPPLY_OK);

	rst_defaults_a: assert property (disable iff (1'b0)
		!RST_B |=> INT_B && !SDA_OE && STANDBY) else $error("reset left outputs busy");
	supply_defaults_a: assert property (disable iff (1'b0)
		!SUPPLY_OK |=> INT_B && ROW_DRIVE_OUTPUTS == 8'h00) else $error("supply drop ignored");
	abort_release_a: assert property (!BUS_ABORT_B [*2] |-> !SDA_OE)
		else $error("data line held during bus abort");
	sda_on_low_a: assert property ($changed(SDA_OE) && BUS_ABORT_B && $past(BUS_ABORT_B)
		|-> !$past(SCL_IN)) else $error("data line moved while clock high");
	standby_rows_a: assert property (STANDBY && $past(STANDBY) |-> ROW_DRIVE_OUTPUTS == 8'h00)
		else $error("rows not low in standby");
	standby_quiet_a: assert property (STANDBY && $past(STANDBY) |-> INT_B && !SDA_OE)
		else $error("standby while busy");
	scan_row_a: assert property (ROW_DRIVE_OUTPUTS != 8'h00 |-> $onehot(~ROW_DRIVE_OUTPUTS))
		else $error("more than one row driven low in scan");
	int_scans_a: assert property ($fell(INT_B) |-> scan_cnt_reg >= 12'h24e)
		else $error("interrupt before three full scans");
	int_rows_quiet_a: assert property (!INT_B && $past(!INT_B) |-> ROW_DRIVE_OUTPUTS == 8'h00)
		else $error("scan ran while interrupt asserted");

	int_cov_c: cover property ($fell(INT_B));
	ack_cov_c: cover property ($rose(SDA_OE));
	abort_cov_c: cover property ($fell(BUS_ABORT_B) && !INT_B);
endmodule // keyscan_asserts

bind keyscan_top keyscan_asserts #(.TICK_CYC(TICK_CYC)) u_keyscan_asserts (
	.SYS_CLK(SYS_CLK),
	.RST_B(RST_B),
	.SUPPLY_OK(SUPPLY_OK),
	.BUS_ABORT_B(BUS_ABORT_B),
	.SCL_IN(SCL_IN),
	.SDA_OE(SDA_OE),
	.ROW_DRIVE_OUTPUTS(ROW_DRIVE_OUTPUTS),
	.INT_B(INT_B),
	.STANDBY(STANDBY)
);
